// file: rtl/tsf_status.v
// Status flag block with AXI4-Lite register access
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tsf_defs.vh"

// Overview of operation
// - Holding-to-shift move sets tx empty
// - Start or repeated start sets tx empty
// - Slave receive-to-transmit switch sets tx empty
// - Tx data write clears empty and done
// - Ninth SCL rise with empty sets done
// - Synchronous last bit out sets done
// - Byte into rx register sets full
// - Rx data read clears full
// - Clear by zero write after read-one
// - Missing ack sets flag when checking
// - Stop after frame sets stop flag
// - Master transmit SDA mismatch sets loss
// - Start seen with own SDA high
// - Synchronous overrun shares bit two
// - Flags reset to zero
// - Ack checking halts continuous transfer
// - Missing ack or loss raises interrupt
module tsf_status (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Shift engine events
	input wire hold_to_shift,
	input wire shift_to_rx,
	input wire [7:0] rx_byte,
	input wire sync_last_tx,
	input wire sync_last_rx,
	input wire slave_rx_to_tx,
	input wire start_issued,
	input wire ack_bit,
	input wire ack_sampled,
	// Bus lines
	input wire scl_i,
	input wire sda_i,
	input wire sda_drive,
	// Outputs to the shift engine
	output reg [7:0] tx_holding_register,
	output reg tx_load,
	output reg transfer_halt,
	// Interrupt
	output reg missing_ack_irq
);

	reg aw_held_q;
	reg w_held_q;
	reg [3:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg [4:0] ctrl_q;
	reg [7:0] rx_data_register;
	reg in_frame_q;
	reg role_q;

	wire [5:0] flag_q;
	wire [7:0] serial_bus_status;
	wire scl_rise;
	wire bus_start;
	wire bus_stop;
	wire sda_mismatch;
	wire ninth_rise;
	wire do_write;
	wire do_read;
	wire wr_status;
	wire wr_tx;
	wire rd_status;
	wire rd_rx;
	wire sync_fmt;
	wire master;
	wire ack_check_enable;
	reg [5:0] set_v;
	reg [5:0] hw_clr_v;

	// Register address match
	function hit;
		input [3:0] a;
		input [3:0] b;
		begin
			hit = (a[3:2] == b[3:2]);
		end
	endfunction

	function known;
		input [3:0] a;
		begin
			known = hit(a, `TSF_ADDR_STATUS) || hit(a, `TSF_ADDR_CTRL) ||
				hit(a, `TSF_ADDR_TXDATA) || hit(a, `TSF_ADDR_RXDATA);
		end
	endfunction

	assign sync_fmt = ctrl_q[`TSF_CTL_FMT];
	assign master = ctrl_q[`TSF_CTL_MASTER];
	assign ack_check_enable = ctrl_q[`TSF_CTL_ACK_CHECK_ENABLE];
	assign serial_bus_status = {flag_q, 2'b00};

	tsf_bus_watch u_watch (
		.aclk(aclk),
		.aresetn(aresetn),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_drive_i(sda_drive),
		.scl_rise_o(scl_rise),
		.start_o(bus_start),
		.stop_o(bus_stop),
		.mismatch_o(sda_mismatch),
		.ninth_o(ninth_rise)
	);

	// Write path: address and data captured independently, either order
	assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
	assign wr_status = do_write && hit(aw_addr_q, `TSF_ADDR_STATUS) && w_strb_q[0];
	assign wr_tx = do_write && hit(aw_addr_q, `TSF_ADDR_TXDATA) && w_strb_q[0];
	assign do_read = s_axi_arvalid && s_axi_arready;
	assign rd_status = do_read && hit(s_axi_araddr, `TSF_ADDR_STATUS);
	assign rd_rx = do_read && hit(s_axi_araddr, `TSF_ADDR_RXDATA);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_addr_q <= `TSF_ADDR_STATUS;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TSF_RESP_OK;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `TSF_RESP_OK;
			s_axi_rdata <= 32'h0000_0000;
		end else begin
			s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_held_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= known(aw_addr_q) ? `TSF_RESP_OK : `TSF_RESP_ERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (do_read) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= known(s_axi_araddr) ? `TSF_RESP_OK : `TSF_RESP_ERR;
				if (hit(s_axi_araddr, `TSF_ADDR_STATUS)) begin
					s_axi_rdata <= {24'h000000, serial_bus_status};
				end else if (hit(s_axi_araddr, `TSF_ADDR_CTRL)) begin
					s_axi_rdata <= {27'h0000000, ctrl_q};
				end else if (hit(s_axi_araddr, `TSF_ADDR_TXDATA)) begin
					s_axi_rdata <= {24'h000000, tx_holding_register};
				end else if (hit(s_axi_araddr, `TSF_ADDR_RXDATA)) begin
					s_axi_rdata <= {24'h000000, rx_data_register};
				end else begin
					s_axi_rdata <= 32'h0000_0000;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Control, data registers and bus framing
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= `TSF_CTRL_RST;
			tx_holding_register <= `TSF_BYTE_RST;
			rx_data_register <= `TSF_BYTE_RST;
			tx_load <= 1'b0;
			in_frame_q <= 1'b0;
			role_q <= 1'b0;
			transfer_halt <= 1'b0;
			missing_ack_irq <= 1'b0;
		end else begin
			if (do_write && hit(aw_addr_q, `TSF_ADDR_CTRL) && w_strb_q[0]) begin
				ctrl_q <= w_data_q[4:0];
			end
			tx_load <= wr_tx;
			if (wr_tx) begin
				tx_holding_register <= w_data_q[7:0];
			end
			if (shift_to_rx) begin
				rx_data_register <= rx_byte;
			end
			role_q <= ctrl_q[`TSF_CTL_ROLE];
			// Stop counts only after a frame; a bare stop on an idle bus is ignored
			if (bus_stop) begin
				in_frame_q <= 1'b0;
			end else if (scl_rise) begin
				in_frame_q <= 1'b1;
			end
			// Halt holds until software clears the missing ack flag
			if (ack_sampled && ack_check_enable && ack_bit) begin
				transfer_halt <= 1'b1;
			end else if (!flag_q[`TSF_BIT_NACK - 2]) begin
				transfer_halt <= 1'b0;
			end
			missing_ack_irq <= ctrl_q[`TSF_CTL_MISSING_ACK_IRQ_ENABLE] &&
				(flag_q[`TSF_BIT_NACK - 2] || flag_q[`TSF_BIT_LOSS - 2]);
		end
	end

	// Set and hardware clear per flag, indexed from bit 2
	always @* begin
		set_v = 6'h00;
		hw_clr_v = 6'h00;
		set_v[`TSF_BIT_TDE - 2] = hold_to_shift ||
			(ctrl_q[`TSF_CTL_ROLE] && !role_q) ||
			start_issued ||
			slave_rx_to_tx;
		set_v[`TSF_BIT_TX_DONE_FLAG - 2] = (!sync_fmt && ninth_rise && flag_q[`TSF_BIT_TDE - 2]) ||
			(sync_fmt && sync_last_tx);
		set_v[`TSF_BIT_RBF - 2] = shift_to_rx;
		set_v[`TSF_BIT_NACK - 2] = ack_check_enable && ack_sampled && ack_bit;
		set_v[`TSF_BIT_STOP - 2] = !sync_fmt && bus_stop && in_frame_q;
		set_v[`TSF_BIT_LOSS - 2] = (!sync_fmt && master && role_q && sda_mismatch) ||
			(!sync_fmt && master && bus_start && sda_drive && !start_issued) ||
			(sync_fmt && sync_last_rx && flag_q[`TSF_BIT_RBF - 2]);
		hw_clr_v[`TSF_BIT_TDE - 2] = wr_tx;
		hw_clr_v[`TSF_BIT_TX_DONE_FLAG - 2] = wr_tx;
		hw_clr_v[`TSF_BIT_RBF - 2] = rd_rx;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_flag
			tsf_flag_cell u_cell (
				.aclk(aclk),
				.aresetn(aresetn),
				.set_i(set_v[gi]),
				.hw_clr_i(hw_clr_v[gi]),
				.rd_i(rd_status),
				.wr_zero_i(wr_status && !w_data_q[gi + 2]),
				.flag_q(flag_q[gi])
			);
		end
	endgenerate

endmodule
`default_nettype wire

// file: rtl/tsf_defs.vh
// Constants for the two-wire status flag block
`ifndef TSF_DEFS_VH
`define TSF_DEFS_VH

// Register byte addresses
`define TSF_ADDR_STATUS 4'h0
`define TSF_ADDR_CTRL 4'h4
`define TSF_ADDR_TXDATA 4'h8
`define TSF_ADDR_RXDATA 4'hC

// Status bit positions
`define TSF_BIT_TDE 7
`define TSF_BIT_TX_DONE_FLAG 6
`define TSF_BIT_RBF 5
`define TSF_BIT_NACK 4
`define TSF_BIT_STOP 3
`define TSF_BIT_LOSS 2

// Control bit positions
`define TSF_CTL_FMT 0
`define TSF_CTL_MASTER 1
`define TSF_CTL_ROLE 2
`define TSF_CTL_ACK_CHECK_ENABLE 3
`define TSF_CTL_MISSING_ACK_IRQ_ENABLE 4

`define TSF_FLAGS_RST 6'h00
`define TSF_CTRL_RST 5'h00
`define TSF_BYTE_RST 8'h00
`define TSF_RESP_OK 2'h0
`define TSF_RESP_ERR 2'h2
`define TSF_SCL_NINTH 4'h9
`define TSF_SCL_ZERO 4'h0

`endif

// file: rtl/tsf_flag_cell.v
// One sticky status flag with read-then-write-zero clearing
`timescale 1ns/1ps
`default_nettype none

module tsf_flag_cell (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Events
	input wire set_i,
	input wire hw_clr_i,
	input wire rd_i,
	input wire wr_zero_i,
	// State
	output reg flag_q
);

	reg armed_q;

	always @(posedge aclk) begin
		if (!aresetn) begin
			flag_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			if (set_i) begin
				flag_q <= 1'b1;
			end else if (hw_clr_i || (wr_zero_i && armed_q)) begin
				flag_q <= 1'b0;
			end
			// Arming only after a read of one keeps stale writes from clearing fresh events
			if (rd_i && flag_q) begin
				armed_q <= 1'b1;
			end else if (!flag_q || wr_zero_i) begin
				armed_q <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// file: rtl/tsf_bus_watch.v
// Bus event detector: SCL rising edges, start and stop, arbitration compare
`timescale 1ns/1ps
`default_nettype none
`include "tsf_defs.vh"

module tsf_bus_watch (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Bus lines
	input wire scl_i,
	input wire sda_i,
	input wire sda_drive_i,
	// Events
	output wire scl_rise_o,
	output wire start_o,
	output wire stop_o,
	output wire mismatch_o,
	output wire ninth_o
);

	reg scl_q;
	reg sda_q;
	reg [3:0] cnt_q;

	assign scl_rise_o = scl_i && !scl_q;
	assign start_o = scl_i && scl_q && sda_q && !sda_i;
	assign stop_o = scl_i && scl_q && !sda_q && sda_i;
	assign mismatch_o = scl_rise_o && (sda_drive_i != sda_i);
	assign ninth_o = scl_rise_o && (cnt_q == `TSF_SCL_NINTH - 4'h1);

	always @(posedge aclk) begin
		if (!aresetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			cnt_q <= `TSF_SCL_ZERO;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
			if (start_o || stop_o || ninth_o) begin
				cnt_q <= `TSF_SCL_ZERO;
			end else if (scl_rise_o) begin
				cnt_q <= cnt_q + 4'h1;
			end
		end
	end

endmodule
`default_nettype wire

// file: test/tsf_status_props.sv
// Port checker for the status flag block
`timescale 1ns/1ps
`default_nettype none
module tsf_status_props (
	// Clock, reset and bus
	input wire aclk, input wire aresetn, input wire s_axi_awready,
	input wire s_axi_bvalid, input wire [1:0] s_axi_bresp, input wire s_axi_arvalid,
	input wire s_axi_arready, input wire s_axi_rvalid, input wire s_axi_rready,
	// Engine side
	input wire ack_sampled, input wire ack_bit, input wire tx_load,
	input wire transfer_halt, input wire missing_ack_irq
);
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
chk_reset_quiet: assert property ($rose(aresetn) |-> !missing_ack_irq && !transfer_halt)
	else $error("output set after reset");
chk_halt_cause: assert property ($rose(transfer_halt) |-> ack_bit && $past(ack_sampled))
	else $error("halt without missing ack");
// A drop must follow a status write, bvalid marks it
chk_halt_drop: assert property ($fell(transfer_halt) |-> s_axi_bvalid || $past(s_axi_bvalid))
	else $error("halt dropped without clear");
chk_irq_clear: assert property ($fell(missing_ack_irq) |->
	s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
	else $error("irq dropped without write");
chk_load_pulse: assert property (tx_load |=> !tx_load)
	else $error("tx load too long");
chk_bresp_ok: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
	else $error("write response not okay");
chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
	else $error("read answer late");
chk_write_answer: assert property ($rose(s_axi_awready) |-> ##[1:3] s_axi_bvalid)
	else $error("write answer late");
chk_read_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
	else $error("read answer repeated");
endmodule
bind tsf_status tsf_status_props u_props (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid,
	.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.ack_sampled, .ack_bit, .tx_load, .transfer_halt, .missing_ack_irq);
`default_nettype wire

// file: test/tsf_i2c_peer.sv
// Remote bus party making start, clocked bits and stop
`timescale 1ns/1ps
`default_nettype none
module tsf_i2c_peer (
	// Clock
	input wire logic aclk,
	// Bus lines, idle high as driven by the peer itself
	output var logic scl,
	output var logic sda
);
initial begin
	scl = 1'h1;
	sda = 1'h1;
end
task step(input logic c, input logic d);
	repeat (4) @(posedge aclk);
	scl <= c;
	sda <= d;
endtask
// Only zeros are sent, so a device driving high sees a mismatch
task frame(input int n);
	step(1'h1, 1'h0);
	repeat (n) begin
		step(1'h0, 1'h0);
		step(1'h1, 1'h0);
	end
	step(1'h1, 1'h1);
endtask
endmodule
`default_nettype wire

// file: test/twowire_status_flags_test.sv
// Self-checking bench for the status flag block
`timescale 1ns/1ps
`default_nettype none
module twowire_status_flags_test;
logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
logic s_axi_arvalid = 0, s_axi_rready = 0, ack_bit = 0, sda_drive = 1;
logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0;
logic [31:0] s_axi_wdata = 0, r;
logic [1:0] rr = 0;
wire [1:0] s_axi_rresp;
logic [6:0] ev = 0;
logic [7:0] rx_byte = 0;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, scl, sda;
wire tx_load, transfer_halt, missing_ack_irq;
wire [1:0] s_axi_bresp;
wire [31:0] s_axi_rdata;
wire [7:0] tx_holding_register;
int err_count = 0, n_tests = 0, cyc = 0;
tsf_status DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hold_to_shift(ev[0]), .shift_to_rx(ev[1]),
	.rx_byte, .sync_last_tx(ev[2]), .sync_last_rx(ev[3]), .slave_rx_to_tx(ev[4]),
	.start_issued(ev[5]), .ack_bit, .ack_sampled(ev[6]), .scl_i(scl), .sda_i(sda), .sda_drive,
	.tx_holding_register, .tx_load, .transfer_halt, .missing_ack_irq);
tsf_i2c_peer u_peer (.aclk, .scl, .sda);
initial forever #25 aclk = ~aclk;
task stop_test;
	$display("errors %0d tests %0d", err_count, n_tests);
	if (err_count == 0 && n_tests > 0)
		$display("Test passed");
	else
		$display("Test failed");
	$finish;
endtask
// Bounded run cuts any hang short
always @(posedge aclk) begin
	cyc <= cyc + 1;
	if (cyc == 20000) begin
		err_count++;
		stop_test;
	end
end
task chk(input logic [31:0] g, input logic [31:0] e);
	n_tests++;
	if (g !== e) begin
		err_count++;
		$display("mismatch %0t got %h exp %h", $time, g, e);
	end
endtask
task wr(input logic [3:0] a, input logic [31:0] d);
	@(posedge aclk);
	s_axi_awaddr <= a;
	s_axi_wdata <= d;
	s_axi_awvalid <= 1;
	s_axi_wvalid <= 1;
	s_axi_bready <= 1;
	do begin
		@(posedge aclk);
		if (s_axi_awready) s_axi_awvalid <= 0;
		if (s_axi_wready) s_axi_wvalid <= 0;
	end while (!s_axi_bvalid);
	s_axi_bready <= 0;
endtask
task rd(input logic [3:0] a, output logic [31:0] d);
	@(posedge aclk);
	s_axi_araddr <= a;
	s_axi_arvalid <= 1;
	s_axi_rready <= 1;
	do begin
		@(posedge aclk);
		if (s_axi_arready) s_axi_arvalid <= 0;
	end while (!s_axi_rvalid);
	d = s_axi_rdata;
	rr = s_axi_rresp;
	s_axi_rready <= 0;
endtask
task sts(input logic [31:0] e);
	rd(4'h0, r);
	chk(r, e);
endtask
task pulse(input logic [6:0] m);
	@(posedge aclk);
	ev <= m;
	@(posedge aclk);
	ev <= 0;
endtask
task clr;
	rd(4'h0, r);
	wr(4'h0, 32'h0);
endtask
task t_reset;
	sts(32'h0);
	rd(4'h4, r);
	chk(r, 32'h0);
	chk(rr, 32'h0);
endtask
task t_tx;
	int s[3] = '{0, 4, 5};
	foreach (s[i]) begin
		pulse(7'(1 << s[i]));
		sts(32'h80);
		clr;
		sts(32'h0);
	end
	pulse(7'h01);
	wr(4'h0, 32'h0);
	sts(32'h80);
	wr(4'h8, 32'hA5);
	sts(32'h0);
	chk(tx_holding_register, 32'hA5);
	wr(4'h4, 32'h5);
	sts(32'h80);
	pulse(7'h04);
	sts(32'hC0);
	wr(4'h8, 32'h0);
	sts(32'h0);
endtask
task t_rx;
	rx_byte <= 8'h3C;
	pulse(7'h02);
	sts(32'h20);
	pulse(7'h0A);
	sts(32'h24);
	rd(4'hC, r);
	chk(r, 32'h3C);
	sts(32'h04);
	clr;
endtask
task t_nack;
	wr(4'h4, 32'h8);
	pulse(7'h40);
	sts(32'h0);
	ack_bit <= 1;
	pulse(7'h40);
	sts(32'h10);
	chk({transfer_halt, missing_ack_irq}, 32'h2);
	wr(4'h4, 32'h18);
	repeat (2) @(posedge aclk);
	chk(missing_ack_irq, 32'h1);
	wr(4'h0, 32'h0);
	repeat (2) @(posedge aclk);
	chk({transfer_halt, missing_ack_irq}, 32'h0);
	wr(4'h4, 32'h0);
	pulse(7'h40);
	sts(32'h0);
	chk(transfer_halt, 32'h0);
	ack_bit <= 0;
endtask
task t_bus;
	pulse(7'h20);
	u_peer.frame(9);
	sts(32'hC8);
	clr;
	wr(4'h4, 32'h6);
	u_peer.frame(9);
	sts(32'hCC);
	clr;
	// Own SDA low and matching the peer: neither loss condition may fire
	sda_drive <= 0;
	u_peer.frame(9);
	sts(32'h08);
	chk(rr, 32'h0);
endtask
initial begin
	repeat (2) @(posedge aclk);
	aresetn <= 1;
	t_reset;
	t_tx;
	t_rx;
	t_nack;
	t_bus;
	stop_test;
end
endmodule
`default_nettype wire
